// >>> rtl/etc_trace_ctrl.sv
/*
 * Trace qualification and capture control of the emulator behind a Wishbone
 * slave: enable, start and stop bit maps, object choice, data trace, ring.
 * Assumes one exec_valid pulse per instruction, with state from before it.
 */
// The Wishbone register port and the register offsets were left to the implementer.
`timescale 1ns/1ps
// Summary of operation
// - One data trace address, 780H-7FFH small mode, 700H-7FFH large mode.
// - Data memory match break compares against that same trace address.
// - Changing the trace object selection clears the trace pointer.
// - Objects: break flags and status, port four/zero, port four/one.
// - Small mode never captures port four data.
// - Enable, start and stop bit kept for every code address.
// - Address mode records instructions whose first-byte enable bit is set.
// - Setting triggers marks start and stop bits and selects trigger mode.
// - Trigger mode records from a start bit until a stop bit.
// - Start instruction is recorded, stop instruction is not.
// - Launch at the start address begins tracing on its second pass.
// - Trigger mode persists across runs until cancelled.
// - Cancel keeps trigger addresses; re-enable reuses them.
// - Reset selects address tracing.
// - Trace storage is an 8192-entry ring, oldest overwritten first.
// - Data writes traced with upper nibble forced to ones unless 8-bit.
// - Traced values show changes one instruction late.
module etc_trace_ctrl (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic wb_cyc,
    input wire logic wb_stb,
    input wire logic wb_we,
    input wire logic [7:0] wb_adr,
    input wire logic [3:0] wb_sel,
    input wire logic [31:0] wb_dat_w,
    output logic [31:0] wb_dat_r,
    output logic wb_ack,
    input wire logic exec_valid,
    input wire logic [11:0] exec_addr,
    input wire logic run_start,
    input wire logic [11:0] run_addr,
    input wire logic dmem_valid,
    input wire logic dmem_we,
    input wire logic dmem_wide,
    input wire logic [10:0] dmem_addr,
    input wire logic [7:0] dmem_wdata,
    input wire logic [7:0] core_ba,
    input wire logic [7:0] core_hl,
    input wire logic core_carry,
    input wire logic [7:0] core_sp,
    input wire logic [3:0] port_two,
    input wire logic [3:0] port_three,
    input wire logic break_condition_flag_a,
    input wire logic break_condition_flag_b,
    input wire logic [3:0] break_status_reg_low,
    input wire logic [3:0] break_status_reg_high,
    input wire logic [3:0] port_zero,
    input wire logic [3:0] port_one,
    input wire logic [3:0] port_four,
    output logic dm_break
);
    logic req, wr, trig_req, tda_ok, tda_wr, obj_wr, ten_wr, large_mode, dm_brk_arm, trig_mode;
    logic overflow, recording, skip_first, next_recording, next_skip, do_record, en_bit, ten_bit;
    logic start_bit, stop_bit, trig_map_we;
    logic [10:0] tdaddr;
    logic [11:0] trig_start, trig_stop, new_start, new_stop, ten_addr;
    logic [11:0] obj_field, start_map_addr, stop_map_addr;
    logic [12:0] tidx, trace_pointer;
    logic [3:0] p4_eff;
    logic [7:0] dm_value;
    logic [31:0] rdata;
    logic [63:0] trace_word, rec_word;
    logic [63:0] trace_mem [etc_pkg::TRACE_DEPTH];
    etc_pkg::etc_obj_t obj;
    etc_pkg::etc_seq_t seq;

    // Partial byte lanes are acked but never write, to keep fields whole
    assign req = wb_cyc & wb_stb & ~wb_ack;
    assign wr = req & wb_we & (wb_sel == etc_pkg::WB_SEL_FULL);
    assign trig_req = wr & (wb_adr == etc_pkg::ADR_TRIG_ADDR);
    assign tda_wr = wr & (wb_adr == etc_pkg::ADR_TDADDR);
    assign ten_wr = wr & (wb_adr == etc_pkg::ADR_TEN);

    assign tda_ok = (wb_dat_w[31:11] == 21'h00_0000)
        && (wb_dat_w[10:0] <= etc_pkg::TDADDR_MAX)
        && (wb_dat_w[10:0] >= (large_mode ? etc_pkg::TDADDR_LARGE_MIN
                                          : etc_pkg::TDADDR_SMALL_MIN));

    assign obj_wr = wr & (wb_adr == etc_pkg::ADR_OBJ)
        & (wb_dat_w[31:2] == 30'h0000_0000) & (wb_dat_w[1:0] != 2'h0);

    etc_bitmap #(.AW(etc_pkg::CODE_AW)) u_enable_map (
        .clk(ref_clk), .wr_en(ten_wr & wb_dat_w[etc_pkg::TEN_WRITE_BIT]),
        .wr_addr(wb_dat_w[11:0]), .wr_bit(wb_dat_w[etc_pkg::TEN_VALUE_BIT]),
        .rd_addr_a(exec_addr), .rd_bit_a(en_bit), .rd_addr_b(ten_addr), .rd_bit_b(ten_bit)
    );

    // clear old marks, then set new ones
    assign trig_map_we = (seq == etc_pkg::etc_seq_clear) | (seq == etc_pkg::etc_seq_set);
    assign start_map_addr = (seq == etc_pkg::etc_seq_set) ? new_start : trig_start;
    assign stop_map_addr = (seq == etc_pkg::etc_seq_set) ? new_stop : trig_stop;

    etc_bitmap #(.AW(etc_pkg::CODE_AW)) u_start_map (
        .clk(ref_clk), .wr_en(trig_map_we), .wr_addr(start_map_addr),
        .wr_bit(seq == etc_pkg::etc_seq_set), .rd_addr_a(exec_addr), .rd_bit_a(start_bit),
        .rd_addr_b(12'h000), .rd_bit_b()
    );

    etc_bitmap #(.AW(etc_pkg::CODE_AW)) u_stop_map (
        .clk(ref_clk), .wr_en(trig_map_we), .wr_addr(stop_map_addr),
        .wr_bit(seq == etc_pkg::etc_seq_set), .rd_addr_a(exec_addr), .rd_bit_a(stop_bit),
        .rd_addr_b(12'h000), .rd_bit_b()
    );

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            large_mode <= 1'b0;
            dm_brk_arm <= 1'b0;
            tdaddr <= etc_pkg::TDADDR_RST;
            obj <= etc_pkg::OBJ_RST;
            ten_addr <= 12'h000;
            tidx <= 13'h0000;
        end else if (wr) begin
            case (wb_adr)
                etc_pkg::ADR_CTRL: begin
                    large_mode <= wb_dat_w[etc_pkg::CTRL_LARGE_BIT];
                    dm_brk_arm <= wb_dat_w[etc_pkg::CTRL_DMBRK_BIT];
                end
                etc_pkg::ADR_TDADDR: begin
                    if (tda_ok) begin
                        tdaddr <= wb_dat_w[10:0];
                    end
                end
                etc_pkg::ADR_OBJ: begin
                    if (obj_wr) begin
                        obj <= etc_pkg::etc_obj_t'(wb_dat_w[1:0]);
                    end
                end
                etc_pkg::ADR_TEN: ten_addr <= wb_dat_w[11:0];
                etc_pkg::ADR_TIDX: tidx <= wb_dat_w[12:0];
            endcase
        end
    end

    // addresses survive cancel; reset picks address mode
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            trig_mode <= 1'b0;
            trig_start <= 12'h000;
            trig_stop <= 12'h000;
            new_start <= 12'h000;
            new_stop <= 12'h000;
            seq <= etc_pkg::etc_seq_idle;
        end else begin
            unique case (seq)
                etc_pkg::etc_seq_idle: begin
                    if (trig_req) begin
                        new_start <= wb_dat_w[11:0];
                        new_stop <= wb_dat_w[etc_pkg::TRIG_STOP_LSB +: 12];
                        seq <= etc_pkg::etc_seq_clear;
                    end else if (wr && wb_adr == etc_pkg::ADR_TRIG_MODE) begin
                        trig_mode <= wb_dat_w[0];
                    end
                end
                etc_pkg::etc_seq_clear: seq <= etc_pkg::etc_seq_set;
                etc_pkg::etc_seq_set: begin
                    trig_start <= new_start;
                    trig_stop <= new_stop;
                    trig_mode <= 1'b1;
                    seq <= etc_pkg::etc_seq_idle;
                end
                default: seq <= etc_pkg::etc_seq_idle;
            endcase
        end
    end

    always_comb begin
        do_record = 1'b0;
        next_recording = recording;
        next_skip = skip_first;
        if (run_start) begin
            next_recording = 1'b0;
            next_skip = trig_mode && (run_addr == trig_start);
        end else if (exec_valid) begin
            if (!trig_mode) begin
                do_record = en_bit;
            end else if (stop_bit) begin
                next_recording = 1'b0;
            end else if (start_bit && skip_first) begin
                next_skip = 1'b0;
            end else if (start_bit) begin
                next_recording = 1'b1;
                do_record = 1'b1;
            end else begin
                do_record = recording;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            recording <= 1'b0;
            skip_first <= 1'b0;
        end else begin
            recording <= next_recording;
            skip_first <= next_skip;
        end
    end

    // port four hidden in small mode
    assign p4_eff = large_mode ? port_four : 4'h0;

    always_comb begin
        unique case (obj)
            etc_pkg::etc_obj_brk: obj_field = {2'b00, break_condition_flag_a,
                break_condition_flag_b, break_status_reg_low, break_status_reg_high};
            etc_pkg::etc_obj_p4p0: obj_field = {4'h0, p4_eff, port_zero};
            etc_pkg::etc_obj_p4p1: obj_field = {4'h0, p4_eff, port_one};
            default: obj_field = 12'h000;
        endcase
    end

    // sampled before the instruction's own effects
    assign rec_word = {11'h000, obj_field, port_three, port_two, dm_value,
        core_sp, core_carry, core_hl, core_ba};

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            dm_value <= etc_pkg::DM_VALUE_RST;
        end else if (dmem_valid && dmem_we && dmem_addr == tdaddr) begin
            dm_value <= dmem_wide ? dmem_wdata : {etc_pkg::DM_HIGH_FILL, dmem_wdata[3:0]};
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            dm_break <= 1'b0;
        end else begin
            dm_break <= dm_brk_arm & dmem_valid & (dmem_addr == tdaddr);
        end
    end

    // ring storage; read port is one cycle late
    always_ff @(posedge ref_clk) begin
        if (do_record) begin
            trace_mem[trace_pointer] <= rec_word;
        end
        trace_word <= trace_mem[tidx];
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            trace_pointer <= 13'h0000;
            overflow <= 1'b0;
        end else if (obj_wr) begin
            trace_pointer <= 13'h0000;
            overflow <= 1'b0;
        end else if (do_record) begin
            trace_pointer <= trace_pointer + 13'h0001;
            if (trace_pointer == {etc_pkg::TRACE_AW{1'b1}}) begin
                overflow <= 1'b1;
            end
        end
    end

    always_comb begin
        rdata = 32'h0000_0000;
        case (wb_adr)
            etc_pkg::ADR_CTRL: begin
                rdata[etc_pkg::CTRL_LARGE_BIT] = large_mode;
                rdata[etc_pkg::CTRL_DMBRK_BIT] = dm_brk_arm;
            end
            etc_pkg::ADR_TDADDR: rdata[10:0] = tdaddr;
            etc_pkg::ADR_OBJ: rdata[1:0] = obj;
            etc_pkg::ADR_TRIG_ADDR: begin
                rdata[11:0] = trig_start;
                rdata[etc_pkg::TRIG_STOP_LSB +: 12] = trig_stop;
            end
            etc_pkg::ADR_TRIG_MODE: begin
                rdata[0] = trig_mode;
                rdata[etc_pkg::TMODE_REC_BIT] = recording;
                rdata[etc_pkg::TMODE_SKIP_BIT] = skip_first;
            end
            etc_pkg::ADR_TEN: begin
                rdata[11:0] = ten_addr;
                rdata[etc_pkg::TEN_VALUE_BIT] = ten_bit;
            end
            etc_pkg::ADR_STATUS: begin
                rdata[12:0] = trace_pointer;
                rdata[etc_pkg::STAT_OVF_BIT] = overflow;
            end
            etc_pkg::ADR_TIDX: rdata[12:0] = tidx;
            etc_pkg::ADR_TLO: rdata = trace_word[31:0];
            etc_pkg::ADR_THI: rdata = trace_word[63:32];
            default: rdata = 32'h0000_0000;
        endcase
    end

    // Trigger writes answer only once both marks are placed
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            wb_ack <= 1'b0;
            wb_dat_r <= 32'h0000_0000;
        end else begin
            wb_ack <= (req & ~trig_req) | (seq == etc_pkg::etc_seq_set);
            if (req && !wb_we) begin
                wb_dat_r <= rdata;
            end
        end
    end

    default clocking @(posedge ref_clk);
    endclocking
    default disable iff (reset);

    tda_range_a: assert property (
        tda_wr && !tda_ok |=> $stable(tdaddr))
        else $error("out of range trace address was stored");

    dm_break_a: assert property (
        dm_brk_arm && dmem_valid && dmem_addr == tdaddr |=> dm_break)
        else $error("data memory break missed");

    obj_clear_a: assert property (
        obj_wr |=> trace_pointer == 13'h0000 && !overflow)
        else $error("pointer not cleared on object change");

    p4_mask_a: assert property (
        !large_mode && obj != etc_pkg::etc_obj_brk |-> obj_field[7:4] == 4'h0)
        else $error("port four captured in small mode");

    addr_mode_a: assert property (
        exec_valid && !run_start && !trig_mode |-> do_record == en_bit)
        else $error("address mode record mismatch");

    trig_seq_a: assert property (
        trig_req && seq == etc_pkg::etc_seq_idle |-> ##2 seq == etc_pkg::etc_seq_set
        ##1 trig_mode && wb_ack && trig_start == $past(new_start))
        else $error("trigger set sequence wrong");

    stop_rec_a: assert property (
        exec_valid && !run_start && trig_mode && stop_bit |-> !do_record ##1 !recording)
        else $error("stop instruction recorded");

    start_rec_a: assert property (
        exec_valid && !run_start && trig_mode && start_bit && !stop_bit && !skip_first
        |-> do_record ##1 recording)
        else $error("start instruction not recorded");

    skip_pass_a: assert property (
        exec_valid && !run_start && trig_mode && start_bit && !stop_bit && skip_first
        |-> !do_record ##1 !skip_first && !recording)
        else $error("launch pass was not skipped");

    ptr_step_a: assert property (
        do_record && !obj_wr |=> trace_pointer == $past(trace_pointer) + 13'h0001)
        else $error("trace pointer did not step");
endmodule

// >>> shared/etc_pkg.sv
/*
 * Shared constants and types of the emulator trace control block.
 * Assumes a 32-bit classic Wishbone register bus with byte addresses.
 */
package etc_pkg;
    localparam int CODE_AW = 12;
    localparam int DMEM_AW = 11;
    localparam int TRACE_AW = 13;
    localparam int TRACE_DEPTH = 8192;
    localparam int REC_W = 64;

    localparam logic [7:0] ADR_CTRL = 8'h00;
    localparam logic [7:0] ADR_TDADDR = 8'h04;
    localparam logic [7:0] ADR_OBJ = 8'h08;
    localparam logic [7:0] ADR_TRIG_ADDR = 8'h0C;
    localparam logic [7:0] ADR_TRIG_MODE = 8'h10;
    localparam logic [7:0] ADR_TEN = 8'h14;
    localparam logic [7:0] ADR_STATUS = 8'h18;
    localparam logic [7:0] ADR_TIDX = 8'h1C;
    localparam logic [7:0] ADR_TLO = 8'h20;
    localparam logic [7:0] ADR_THI = 8'h24;

    localparam int CTRL_LARGE_BIT = 0;
    localparam int CTRL_DMBRK_BIT = 1;
    localparam int TRIG_STOP_LSB = 16;
    localparam int TMODE_REC_BIT = 1;
    localparam int TMODE_SKIP_BIT = 2;
    localparam int TEN_VALUE_BIT = 16;
    localparam int TEN_WRITE_BIT = 31;
    localparam int STAT_OVF_BIT = 16;

    localparam logic [10:0] TDADDR_SMALL_MIN = 11'h780;
    localparam logic [10:0] TDADDR_LARGE_MIN = 11'h700;
    localparam logic [10:0] TDADDR_MAX = 11'h7FF;
    localparam logic [10:0] TDADDR_RST = 11'h780;
    localparam logic [3:0] DM_HIGH_FILL = 4'hF;
    localparam logic [7:0] DM_VALUE_RST = 8'h00;
    localparam logic [3:0] WB_SEL_FULL = 4'hF;

    typedef enum logic [1:0] {
        etc_obj_brk = 2'h1,
        etc_obj_p4p0 = 2'h2,
        etc_obj_p4p1 = 2'h3
    } etc_obj_t;

    localparam etc_obj_t OBJ_RST = etc_obj_brk;

    typedef enum logic [1:0] {
        etc_seq_idle,
        etc_seq_clear,
        etc_seq_set
    } etc_seq_t;
endpackage

// >>> rtl/etc_bitmap.sv
/*
 * One bit per code memory address, with one write port and two
 * asynchronous read ports.
 * Assumes the owner sequences writes; contents are not reset.
 */
`timescale 1ns/1ps
module etc_bitmap #(
    parameter int AW = 12
) (
    input wire logic clk,
    input wire logic wr_en,
    input wire logic [AW-1:0] wr_addr,
    input wire logic wr_bit,
    input wire logic [AW-1:0] rd_addr_a,
    output logic rd_bit_a,
    input wire logic [AW-1:0] rd_addr_b,
    output logic rd_bit_b
);
    logic [(1<<AW)-1:0] bits;

    always_ff @(posedge clk) begin
        if (wr_en) begin
            bits[wr_addr] <= wr_bit;
        end
    end

    assign rd_bit_a = bits[rd_addr_a];
    assign rd_bit_b = bits[rd_addr_b];
endmodule

// >>> bench/etc_core_model.sv
/*
 * Behavioural model of the emulated core: instruction, launch and data
 * memory strobes, plus the register and port levels seen by the tracer.
 * Assumes callers enter its tasks just after a rising edge of ref_clk.
 */
`timescale 1ns/1ps
module etc_core_model (
    input wire logic ref_clk,
    output logic exec_valid,
    output logic [11:0] exec_addr,
    output logic run_start,
    output logic [11:0] run_addr,
    output logic dmem_valid,
    output logic dmem_we,
    output logic dmem_wide,
    output logic [10:0] dmem_addr,
    output logic [7:0] dmem_wdata,
    output logic [63:0] levels
);
    initial begin
        {exec_valid, run_start, dmem_valid, dmem_we, dmem_wide} = 5'h00;
        {exec_addr, run_addr, dmem_addr, dmem_wdata} = '0;
        levels = '0;
    end

    // Bursts hold the strobe; released buses show the inverse, not the old value
    task automatic exec(input logic [11:0] a, input logic [63:0] v, input int n);
        @(posedge ref_clk);
        exec_valid <= 1'b1;
        exec_addr <= a;
        levels <= v;
        repeat (n) @(posedge ref_clk);
        exec_valid <= 1'b0;
        exec_addr <= ~a;
    endtask

    task automatic launch(input logic [11:0] a);
        @(posedge ref_clk);
        run_start <= 1'b1;
        run_addr <= a;
        @(posedge ref_clk);
        run_start <= 1'b0;
        run_addr <= ~a;
    endtask

    task automatic access(input logic [10:0] a, input logic [7:0] d, input logic we,
                          input logic wide);
        @(posedge ref_clk);
        {dmem_valid, dmem_we, dmem_wide} <= {1'b1, we, wide};
        dmem_addr <= a;
        dmem_wdata <= d;
        @(posedge ref_clk);
        {dmem_valid, dmem_we, dmem_wide} <= 3'b000;
        dmem_addr <= ~a;
        dmem_wdata <= ~d;
    endtask
endmodule

// >>> bench/test_emulator_trace_control.sv
/*
 * Self-checking bench of the trace control block: Wishbone traffic, core
 * model stimulus and a queue scoreboard that checks every read answer.
 * Assumes the register map and record layout of the trace control block.
 */
`timescale 1ns/1ps
module test_emulator_trace_control;
    typedef struct {logic [31:0] exp; logic [31:0] mask;} etc_note_t;
    logic ref_clk = 1'b0;
    logic reset = 1'b1;
    logic wb_cyc = 1'b0;
    logic wb_stb = 1'b0;
    logic wb_we = 1'b0;
    logic [7:0] wb_adr = 8'h00;
    logic [3:0] wb_sel = 4'h0;
    logic [31:0] wb_dat_w = 32'h0000_0000;
    logic [31:0] wb_dat_r;
    logic wb_ack, dm_break, exec_valid, run_start, dmem_valid, dmem_we, dmem_wide;
    logic [11:0] exec_addr, run_addr;
    logic [10:0] dmem_addr;
    logic [7:0] dmem_wdata;
    logic [63:0] lv;
    logic [31:0] seed = 32'h5cad;
    logic [7:0] dm_exp = etc_pkg::DM_VALUE_RST;
    etc_note_t notes[$];
    etc_note_t cur;
    int miscompares = 0;
    int comparisons = 0;
    int cycles = 0;

    etc_trace_ctrl uut (
        .ref_clk(ref_clk), .reset(reset), .wb_cyc(wb_cyc), .wb_stb(wb_stb), .wb_we(wb_we),
        .wb_adr(wb_adr), .wb_sel(wb_sel), .wb_dat_w(wb_dat_w), .wb_dat_r(wb_dat_r),
        .wb_ack(wb_ack), .exec_valid(exec_valid), .exec_addr(exec_addr),
        .run_start(run_start), .run_addr(run_addr), .dmem_valid(dmem_valid),
        .dmem_we(dmem_we), .dmem_wide(dmem_wide), .dmem_addr(dmem_addr),
        .dmem_wdata(dmem_wdata), .core_ba(lv[7:0]), .core_hl(lv[15:8]),
        .core_carry(lv[16]), .core_sp(lv[24:17]), .port_two(lv[28:25]),
        .port_three(lv[32:29]), .break_condition_flag_a(lv[33]),
        .break_condition_flag_b(lv[34]), .break_status_reg_low(lv[38:35]),
        .break_status_reg_high(lv[42:39]), .port_zero(lv[46:43]), .port_one(lv[50:47]),
        .port_four(lv[54:51]), .dm_break(dm_break)
    );

    etc_core_model core (
        .ref_clk(ref_clk), .exec_valid(exec_valid), .exec_addr(exec_addr),
        .run_start(run_start), .run_addr(run_addr), .dmem_valid(dmem_valid),
        .dmem_we(dmem_we), .dmem_wide(dmem_wide), .dmem_addr(dmem_addr),
        .dmem_wdata(dmem_wdata), .levels(lv)
    );

    initial begin
        forever #10 ref_clk = ~ref_clk;
    end

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input logic [31:0] m);
        comparisons++;
        if (((got ^ exp) & m) !== 32'h0000_0000) begin
            miscompares++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wrap_up();
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // Read answers are checked at the ack edge, against the oldest note
    always @(posedge ref_clk) begin
        cycles++;
        if (wb_ack === 1'b1 && wb_we === 1'b0 && notes.size() > 0) begin
            cur = notes.pop_front();
            chk(wb_dat_r, cur.exp, cur.mask);
        end
        if (cycles == 40000) begin
            miscompares++;
            wrap_up();
        end
    end

    task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        {wb_cyc, wb_stb, wb_we} <= {2'b11, we};
        wb_adr <= a;
        wb_sel <= etc_pkg::WB_SEL_FULL;
        wb_dat_w <= d;
        @(posedge ref_clk);
        while (wb_ack !== 1'b1) @(posedge ref_clk);
        {wb_cyc, wb_stb, wb_we} <= 3'b000;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        wb(1'b1, a, d);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
        notes.push_back('{e, m});
        wb(1'b0, a, 32'h0000_0000);
    endtask

    task automatic st(input int p, input logic o);
        rd(etc_pkg::ADR_STATUS, {15'h0000, o, 3'b000, p[12:0]}, 32'h0001_1FFF);
    endtask

    task automatic entry(input int i, input logic [63:0] e);
        wr(etc_pkg::ADR_TIDX, 32'(i));
        rd(etc_pkg::ADR_TLO, e[31:0], 32'hFFFF_FFFF);
        rd(etc_pkg::ADR_THI, e[63:32], 32'hFFFF_FFFF);
    endtask

    task automatic steps(input logic [11:0] s[5], input int n);
        for (int i = 0; i < n; i++) core.exec(s[i], lv, 1);
    endtask

    function automatic logic [63:0] rec(input logic [63:0] v, input logic [1:0] o,
                                        input logic big);
        logic [11:0] obj;
        logic [3:0] p4;
        p4 = big ? v[54:51] : 4'h0;
        case (o)
            2'h1: obj = {2'b00, v[33], v[34], v[38:35], v[42:39]};
            2'h2: obj = {4'h0, p4, v[46:43]};
            default: obj = {4'h0, p4, v[50:47]};
        endcase
        return {11'h000, obj, v[32:29], v[28:25], dm_exp, v[24:0]};
    endfunction

    initial begin
        logic [63:0] v;
        logic [31:0] r;
        logic hit;
        int cnt;
        repeat (3) @(posedge ref_clk);
        reset <= 1'b0;
        rd(etc_pkg::ADR_CTRL, 32'h0000_0000, 32'h0000_0003);
        rd(etc_pkg::ADR_TDADDR, {21'h00_0000, etc_pkg::TDADDR_RST}, 32'h0000_07FF);
        rd(etc_pkg::ADR_OBJ, 32'h0000_0001, 32'h0000_0003);
        rd(etc_pkg::ADR_TRIG_MODE, 32'h0000_0000, 32'h0000_0001);
        st(0, 1'b0);
        rd(8'h40, 32'h0000_0000, 32'hFFFF_FFFF);
        cnt = 0;
        for (int a = 0; a < 64; a++) begin
            r = rnd();
            r[0] = (a == 48) || (a < 16 && r[0]);
            if (a < 16 && r[0]) cnt++;
            wr(etc_pkg::ADR_TEN, {1'b1, 14'h0000, r[0], 4'h0, 12'(a)});
        end
        wr(etc_pkg::ADR_TEN, 32'h0000_0030);
        rd(etc_pkg::ADR_TEN, 32'h0001_0030, 32'h0001_0FFF);
        v = {rnd(), rnd()};
        for (int a = 0; a < 16; a++) core.exec(12'(a), v, 1);
        st(cnt, 1'b0);
        for (int m = 0; m < 2; m++) begin
            for (int o = 1; o < 4; o++) begin
                wr(etc_pkg::ADR_CTRL, 32'(m));
                wr(etc_pkg::ADR_OBJ, 32'(o));
                st(0, 1'b0);
                v = {rnd(), rnd()};
                r = rnd();
                core.access(etc_pkg::TDADDR_RST, r[7:0], 1'b1, r[8]);
                core.access(11'h7FE, ~r[7:0], 1'b1, 1'b1);
                dm_exp = r[8] ? r[7:0] : {etc_pkg::DM_HIGH_FILL, r[3:0]};
                core.exec(12'h030, v, 1);
                st(1, 1'b0);
                entry(0, rec(v, 2'(o), m[0]));
            end
        end
        wr(etc_pkg::ADR_CTRL, 32'h0000_0000);
        wr(etc_pkg::ADR_TDADDR, 32'h0000_0700);
        rd(etc_pkg::ADR_TDADDR, 32'h0000_0780, 32'h0000_07FF);
        wr(etc_pkg::ADR_TDADDR, 32'h0000_07FF);
        rd(etc_pkg::ADR_TDADDR, 32'h0000_07FF, 32'h0000_07FF);
        wr(etc_pkg::ADR_CTRL, 32'h0000_0003);
        wr(etc_pkg::ADR_TDADDR, 32'h0000_0700);
        rd(etc_pkg::ADR_TDADDR, 32'h0000_0700, 32'h0000_07FF);
        for (int k = 0; k < 2; k++) begin
            core.access(11'h700 + 11'(k), 8'h00, 1'b0, 1'b0);
            #1 hit = dm_break;
            repeat (2) begin
                @(posedge ref_clk);
                #1 hit |= dm_break;
            end
            chk(32'(hit), 32'(k == 0), 32'h0000_0001);
        end
        // marks stay on first bytes inside the small range
        wr(etc_pkg::ADR_TRIG_ADDR, 32'h0021_001F);
        wr(etc_pkg::ADR_TRIG_ADDR, 32'h0022_0025);
        wr(etc_pkg::ADR_TRIG_ADDR, 32'h0024_0020);
        rd(etc_pkg::ADR_TRIG_MODE, 32'h0000_0001, 32'h0000_0001);
        rd(etc_pkg::ADR_TRIG_ADDR, 32'h0024_0020, 32'h0FFF_0FFF);
        wr(etc_pkg::ADR_OBJ, 32'h0000_0001);
        core.launch(12'h000);
        steps('{12'h01F, 12'h020, 12'h021, 12'h024, 12'h025}, 5);
        st(2, 1'b0);
        core.launch(12'h020);
        steps('{12'h020, 12'h021, 12'h020, 12'h021, 12'h024}, 5);
        st(4, 1'b0);
        wr(etc_pkg::ADR_TRIG_MODE, 32'h0000_0000);
        rd(etc_pkg::ADR_TRIG_MODE, 32'h0000_0000, 32'h0000_0001);
        steps('{12'h020, 12'h021, 12'h024, 12'h000, 12'h000}, 3);
        st(4, 1'b0);
        wr(etc_pkg::ADR_TRIG_MODE, 32'h0000_0001);
        rd(etc_pkg::ADR_TRIG_ADDR, 32'h0024_0020, 32'h0FFF_0FFF);
        core.launch(12'h000);
        steps('{12'h020, 12'h024, 12'h000, 12'h000, 12'h000}, 2);
        st(5, 1'b0);
        wr(etc_pkg::ADR_TRIG_MODE, 32'h0000_0000);
        wr(etc_pkg::ADR_OBJ, 32'h0000_0002);
        core.access(11'h700, 8'hA5, 1'b1, 1'b1);
        dm_exp = 8'hA5;
        v = {rnd(), rnd()};
        core.exec(12'h030, v, etc_pkg::TRACE_DEPTH);
        st(0, 1'b1);
        core.exec(12'h030, lv, 1);
        st(1, 1'b1);
        entry(0, rec(v, 2'h2, 1'b1));
        @(posedge ref_clk);
        chk(32'(notes.size()), 32'h0000_0000, 32'hFFFF_FFFF);
        wrap_up();
    end
endmodule
